//--- design/ahs_switcher.sv
// Decision logic turning field samples into speed output edges.
// Assumes samples and extrema arrive synchronous to core_clk_in from the digital core.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Edge only when switching threshold crossed after a hysteresis crossing
// - Positive and negative hysteresis crossings must alternate to re-arm
// - Switching crossings without hysteresis crossing leave output unchanged
// - Armed edge happens at the switching crossing sample, not hysteresis
// - After rising through positive hysteresis, next switching crossing falls output
// - Hysteresis offset is one eighth of latest peak-to-peak, updated on each fresh extrema pair
// - Positive hysteresis threshold is switching threshold plus offset
// - Negative hysteresis threshold is switching threshold minus offset
// - Without noise, edges fall exactly on switching threshold crossings
// - Speed output floats while supply is below reset level
// - Switching threshold is mean of last minimum and maximum
// - Amplitude is last maximum minus last minimum
// - Output held high for 700 us power-on time before switching
module ahs_switcher
  import ahs_pkg::*;
(
  // Clock and reset
  input  wire logic         core_clk_in,
  input  wire logic         rst_n_in,
  // Supply monitor, low while supply is under the reset level
  input  wire logic         supply_ok_in,
  // Sample stream and extrema from the tracking core
  input  wire ahs_sample_t  sample_in,
  input  wire ahs_extrema_t extrema_in,
  // Open-drain speed output
  input  wire logic         speed_pin_in,
  output logic              speed_pin_out,
  output logic              speed_pin_oe_out,
  // Status
  output logic              speed_level_out,
  output logic              running_out
);

  // ----------------------------------------
  // Supply monitor synchroniser
  // ----------------------------------------
  logic sup_meta_r;
  logic sup_sync_r;

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      sup_meta_r <= 1'b0;
      sup_sync_r <= 1'b0;
    end else begin
      sup_meta_r <= supply_ok_in;
      sup_sync_r <= sup_meta_r;
    end
  end

  // ----------------------------------------
  // Power-on timer
  // ----------------------------------------
  localparam logic [PWR_CNT_W-1:0] PWR_LAST = PWR_CNT_W'(PWR_ON_CYCLES - 1);
  logic [PWR_CNT_W-1:0] pwr_cnt_r;
  logic                 pwr_done_r;

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in || !sup_sync_r) begin
      pwr_cnt_r  <= '0;
      pwr_done_r <= 1'b0;
    end else if (!pwr_done_r) begin
      if (pwr_cnt_r == PWR_LAST) begin
        pwr_done_r <= 1'b1;
      end
      pwr_cnt_r <= pwr_cnt_r + PWR_CNT_W'(1);
    end
  end

  // ----------------------------------------
  // Threshold computation
  // ----------------------------------------
  logic signed [SAMPLE_W-1:0] sw_thr_r;
  logic signed [SAMPLE_W-1:0] pos_thr_r;
  logic signed [SAMPLE_W-1:0] neg_thr_r;
  logic                       thr_valid_r;
  logic signed [SAMPLE_W:0]   sum_w;
  logic signed [SAMPLE_W:0]   amp_w;
  logic signed [SAMPLE_W:0]   offs_w;
  logic signed [SAMPLE_W-1:0] mean_w;

  always_comb begin
    sum_w  = (SAMPLE_W+1)'(extrema_in.max_val) + (SAMPLE_W+1)'(extrema_in.min_val);
    mean_w = SAMPLE_W'(sum_w >>> 1);
    amp_w  = (SAMPLE_W+1)'(extrema_in.max_val) - (SAMPLE_W+1)'(extrema_in.min_val);
    offs_w = amp_w >>> HYST_SHIFT;
  end

  // Thresholds adapt only on a fresh extrema pair, keeping decisions stable between
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      sw_thr_r    <= '0;
      pos_thr_r   <= '0;
      neg_thr_r   <= '0;
      thr_valid_r <= 1'b0;
    end else if (extrema_in.valid) begin
      sw_thr_r    <= mean_w;
      pos_thr_r   <= SAMPLE_W'((SAMPLE_W+1)'(mean_w) + offs_w);
      neg_thr_r   <= SAMPLE_W'((SAMPLE_W+1)'(mean_w) - offs_w);
      thr_valid_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // Arming and output decision
  // ----------------------------------------
  ahs_arm_t arm_r;
  ahs_arm_t arm_nxt;
  ahs_arm_t last_dir_r;
  logic     level_r;
  logic     level_nxt;
  logic     active_w;
  logic     above_pos_w;
  logic     below_neg_w;
  logic     above_sw_w;

  assign active_w    = pwr_done_r && thr_valid_r && sample_in.valid;
  assign above_pos_w = sample_in.sample > pos_thr_r;
  assign below_neg_w = sample_in.sample < neg_thr_r;
  assign above_sw_w  = sample_in.sample >= sw_thr_r;

  always_comb begin
    arm_nxt   = arm_r;
    level_nxt = level_r;
    if (active_w) begin
      unique case (arm_r)
        ARM_IDLE: begin
          if (above_pos_w && last_dir_r != ARM_POS) begin
            arm_nxt = ARM_POS;
          end else if (below_neg_w && last_dir_r != ARM_NEG) begin
            arm_nxt = ARM_NEG;
          end
        end
        ARM_POS: begin
          // edges sit on the switching crossing
          if (!above_sw_w) begin
            level_nxt = 1'b0;
            arm_nxt   = ARM_IDLE;
          end
        end
        ARM_NEG: begin
          if (above_sw_w) begin
            level_nxt = 1'b1;
            arm_nxt   = ARM_IDLE;
          end
        end
        default: arm_nxt = ARM_IDLE;
      endcase
    end
  end

  // armed state, direction memory and output level
  // Supply loss sets the level high on the same edge as the timer resets, so no low level outlives it
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in || !pwr_done_r || !sup_sync_r) begin
      arm_r      <= ARM_IDLE;
      last_dir_r <= ARM_IDLE;
      level_r    <= 1'b1;
    end else begin
      arm_r   <= arm_nxt;
      level_r <= level_nxt;
      if (arm_r == ARM_IDLE && arm_nxt != ARM_IDLE) begin
        last_dir_r <= arm_nxt;
      end
    end
  end

  // ----------------------------------------
  // Open-drain driver
  // ----------------------------------------
  // floating below reset level; low driven only for a low level
  assign speed_pin_out    = 1'b0;
  assign speed_pin_oe_out = sup_sync_r && !level_r;
  assign speed_level_out  = level_r;
  assign running_out      = pwr_done_r && thr_valid_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  logic pin_seen_r;
  always_ff @(posedge core_clk_in) begin
    pin_seen_r <= speed_pin_in;
  end

  a_edge_needs_arm: assert property ($changed(level_r) && pwr_done_r
    |-> $past(arm_r) != ARM_IDLE)
    else $error("Output edge without hysteresis arming");
  a_idle_no_edge: assert property (pwr_done_r && $past(pwr_done_r) && $past(arm_r) == ARM_IDLE
    |-> $stable(level_r))
    else $error("Output changed while not armed");
  a_fall_after_pos: assert property (pwr_done_r && arm_r == ARM_POS && active_w && !above_sw_w
    |=> !level_r && arm_r == ARM_IDLE)
    else $error("Missing falling edge after positive arming");
  a_rise_after_neg: assert property (pwr_done_r && arm_r == ARM_NEG && active_w && above_sw_w
    |=> level_r && arm_r == ARM_IDLE)
    else $error("Missing rising edge after negative arming");
  a_alternate_arm: assert property (arm_r == ARM_IDLE && $past(arm_r) != ARM_IDLE
    |-> arm_nxt != last_dir_r || arm_nxt == ARM_IDLE)
    else $error("Same hysteresis direction armed twice");
  a_arm_at_cross: assert property (arm_r == ARM_POS && $past(arm_r) == ARM_IDLE
    && pwr_done_r |-> $past(above_pos_w))
    else $error("Positive arming without threshold crossing");
  a_pos_thr_calc: assert property (extrema_in.valid
    |=> pos_thr_r - sw_thr_r == SAMPLE_W'($past(offs_w)))
    else $error("Positive threshold offset wrong");
  a_neg_thr_calc: assert property (extrema_in.valid
    |=> sw_thr_r - neg_thr_r == SAMPLE_W'($past(offs_w)))
    else $error("Negative threshold offset wrong");
  a_mean_calc: assert property (extrema_in.valid |=> sw_thr_r == $past(mean_w))
    else $error("Switching threshold not mean of extrema");
  a_hold_high: assert property (!pwr_done_r |-> level_r && !speed_pin_oe_out)
    else $error("Output not high during power-on");
  a_float_low_sup: assert property (!sup_sync_r |-> !speed_pin_oe_out)
    else $error("Output driven below reset level");

  c_fall_edge: cover property ($fell(level_r));
  c_rise_edge: cover property ($rose(level_r));
  c_noise_ignored: cover property (arm_r == ARM_IDLE && active_w && !above_sw_w
    && level_r == 1'b0);
  c_power_done: cover property ($rose(pwr_done_r));
  c_same_dir_refused: cover property (active_w && arm_r == ARM_IDLE && last_dir_r == ARM_POS
    && above_pos_w);

  // ----------------------------------------
  // Arming and direction checks
  // ----------------------------------------
  // negative arming point
  a_neg_arm_cross: assert property (arm_r == ARM_NEG && $past(arm_r) == ARM_IDLE
    && pwr_done_r |-> $past(below_neg_w))
    else $error("Negative arming without threshold crossing");
  a_dir_memory: assert property (arm_r != ARM_IDLE |-> last_dir_r == arm_r)
    else $error("Direction memory differs from armed state");
  a_pos_refused: assert property (active_w && arm_r == ARM_IDLE && last_dir_r == ARM_POS
    && !below_neg_w |=> arm_r == ARM_IDLE)
    else $error("Positive crossing re-armed twice in a row");
  a_neg_refused: assert property (active_w && arm_r == ARM_IDLE && last_dir_r == ARM_NEG
    && !above_pos_w |=> arm_r == ARM_IDLE)
    else $error("Negative crossing re-armed twice in a row");
  a_pos_hold: assert property (arm_r == ARM_POS && active_w && above_sw_w
    |=> arm_r == ARM_POS && $stable(level_r))
    else $error("Positive arming left without switching crossing");
  a_neg_hold: assert property (arm_r == ARM_NEG && active_w && !above_sw_w
    |=> arm_r == ARM_NEG && $stable(level_r))
    else $error("Negative arming left without switching crossing");
  a_fall_at_sw: assert property ($fell(level_r) && pwr_done_r
    |-> $past(sample_in.sample) < $past(sw_thr_r))
    else $error("Falling edge away from switching threshold");
  a_rise_at_sw: assert property ($rose(level_r) && pwr_done_r
    |-> $past(sample_in.sample) >= $past(sw_thr_r))
    else $error("Rising edge away from switching threshold");

  // ----------------------------------------
  // Threshold, timer and pin checks
  // ----------------------------------------
  // offset is an eighth
  a_offset_eighth: assert property (extrema_in.valid
    |-> amp_w - (offs_w <<< HYST_SHIFT) >= 0 && amp_w - (offs_w <<< HYST_SHIFT) < 8)
    else $error("Hysteresis offset not one eighth of amplitude");
  a_thr_hold: assert property (!extrema_in.valid
    |=> $stable(sw_thr_r) && $stable(pos_thr_r) && $stable(neg_thr_r))
    else $error("Thresholds moved without a fresh extrema pair");
  a_pwr_count: assert property ($rose(pwr_done_r)
    |-> pwr_cnt_r == PWR_LAST + PWR_CNT_W'(1))
    else $error("Power-on time ended at the wrong count");
  a_oe_follows: assert property (sup_sync_r
    |-> speed_pin_oe_out == !level_r)
    else $error("Pin drive does not follow output level");
  a_pin_pulled_low: assert property ($past(speed_pin_oe_out)
    |-> !pin_seen_r)
    else $error("Pin not low while driven");

endmodule : ahs_switcher

`default_nettype wire

//--- design/ahs_pkg.sv
// Package for the adaptive hysteresis switcher: widths, timing and carriers.
// Assumes a 100 MHz core clock and signed field samples from a tracking converter.
package ahs_pkg;

  // ----------------------------------------
  // Widths and timing
  // ----------------------------------------
  localparam int          SAMPLE_W       = 16;
  localparam int          CLK_MHZ        = 100;
  localparam int          PWR_ON_TIME_US = 700;
  localparam int          PWR_ON_CYCLES  = PWR_ON_TIME_US * CLK_MHZ;
  localparam int          PWR_CNT_W      = 17;
  // Offset is amplitude divided by eight (12.5 percent)
  localparam int          HYST_SHIFT     = 3;
  localparam logic [1:0]  ARM_NONE       = 2'h0;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic signed [SAMPLE_W-1:0] sample;
    logic                       valid;
  } ahs_sample_t;

  typedef struct packed {
    logic signed [SAMPLE_W-1:0] min_val;
    logic signed [SAMPLE_W-1:0] max_val;
    logic                       valid;
  } ahs_extrema_t;

  typedef enum logic [1:0] {
    ARM_IDLE = 2'b00,
    ARM_POS  = 2'b01,
    ARM_NEG  = 2'b11
  } ahs_arm_t;

endpackage : ahs_pkg

//--- verification/ahs_ecu_model.sv
// Engine control unit side: pull-up on the speed line, counts output pulses.
// Assumes the block drives the line open drain, enable high pulling low.
`timescale 1ns/1ps
`default_nettype none
module ahs_ecu_model (
  // Line from the block
  input  wire logic       core_clk_in,
  input  wire logic       pin_drv_in,
  input  wire logic       pin_oe_in,
  // Resolved line and pulse count
  output logic            line_out,
  output logic [7:0]      pulses_out
);
  logic line_r;
  // Pull-up wins whenever the block lets go, so a floating line never reads low
  assign line_out = pin_oe_in ? pin_drv_in : 1'b1;
  initial begin
    pulses_out = 8'h00;
    line_r = 1'b1;
  end
  always @(posedge core_clk_in) begin
    if (line_r && !line_out) pulses_out <= pulses_out + 8'h01;
    line_r <= line_out;
  end
endmodule : ahs_ecu_model
`default_nettype wire

//--- verification/adaptive_hysteresis_switcher_test.sv
// Self-checking bench for the hysteresis switcher with an ECU line model.
// Assumes the full 700 us power-on wait, since that count is not a parameter.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin err_count++; \
  $display("CHECK FAILED %s exp %0d got %0d", nm, ex, gt); end end
module adaptive_hysteresis_switcher_test;
  import ahs_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, sup = 1'b0;
  ahs_sample_t smp = '0;
  ahs_extrema_t ext = '0;
  wire logic pin, drv, oe, lvl, run;
  wire logic [7:0] pulses;
  int err_count = 0, checks_done = 0, cyc = 0, sw = 0, off = 0, arm = 0, lvl_m = 1, fcnt = 0;
  int lst = 0;
  int q_lvl[$], q_cyc[$];
  logic [31:0] seed = 32'h2bfa_d32e;
  int seq[] = '{300, -5, 50, -50, 50, -300, -300, 0, -50, 50, 200, -1, 201, 199, -1, -200,
                0, -201, -200, 0};
  always #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  ahs_switcher u_ahs_switcher (.core_clk_in(clk), .rst_n_in(rst_n), .supply_ok_in(sup),
    .sample_in(smp), .extrema_in(ext), .speed_pin_in(pin), .speed_pin_out(drv),
    .speed_pin_oe_out(oe), .speed_level_out(lvl), .running_out(run));
  ahs_ecu_model u_ahs_ecu_model (.core_clk_in(clk), .pin_drv_in(drv), .pin_oe_in(oe),
    .line_out(pin), .pulses_out(pulses));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs
  task automatic send(input int v, input bit live);
    @(posedge clk);
    smp <= '{sample: v[15:0], valid: 1'b1};
    if (live) begin
      if ((arm == 1 && v < sw) || (arm == 2 && v >= sw)) begin
        if (lvl_m != (arm == 2)) begin
          lvl_m = (arm == 2);
          fcnt += (lvl_m == 0);
          q_lvl.push_back(lvl_m);
          q_cyc.push_back(cyc + 2);
        end
        arm = 0;
      end else if (arm == 0 && v > sw + off && lst != 1) begin
        arm = 1;
        lst = 1;
      end else if (arm == 0 && v < sw - off && lst != 2) begin
        arm = 2;
        lst = 2;
      end
    end
  endtask : send
  task automatic set_ext(input int mn, input int mx);
    @(posedge clk);
    ext <= '{min_val: mn[15:0], max_val: mx[15:0], valid: 1'b1};
    smp.valid <= 1'b0;
    sw = (mx + mn) >>> 1;
    off = (mx - mn) >>> 3;
    @(posedge clk);
    ext.valid <= 1'b0;
  endtask : set_ext
  task automatic results();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  initial begin : mon
    logic prev;
    prev = 1'b1;
    wait (rst_n);
    forever begin
      @(posedge clk);
      #1;
      if (lvl !== prev) begin
        `CHK("edge_cycle", q_cyc.size() ? q_cyc.pop_front() : -1, cyc)
        `CHK("edge_level", q_lvl.size() ? q_lvl.pop_front() : -1, lvl)
        prev = lvl;
      end
      if (sup) `CHK("line_level", lvl, pin)
    end
  end
  initial begin
    repeat (PWR_ON_CYCLES + 5000) @(posedge clk);
    err_count++;
    results();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (20) @(posedge clk);
    #1;
    `CHK("oe_no_supply", 1'b0, oe)
    `CHK("pin_no_supply", 1'b1, pin)
    @(posedge clk);
    sup <= 1'b1;
    // Samples during power-on must leave the line alone
    send(300, 0);
    send(-5, 0);
    repeat (PWR_ON_CYCLES - 100) @(posedge clk);
    `CHK("run_early", 1'b0, run)
    `CHK("lvl_power_on", 1'b1, lvl)
    repeat (200) @(posedge clk);
    set_ext(-800, 800);
    repeat (300) if (run !== 1'b1) @(posedge clk);
    `CHK("running", 1'b1, run)
    foreach (seq[i]) send(seq[i], 1);
    // Thresholds follow a shifted signal
    set_ext(-200, 1400);
    repeat (300) begin
      seed = xs(seed);
      send(int'(seed % 32'h0000_07d1) - 400, 1);
    end
    @(posedge clk);
    smp.valid <= 1'b0;
    repeat (10) @(posedge clk);
    `CHK("pending_edges", 0, q_cyc.size())
    `CHK("pulse_count", fcnt[7:0], pulses)
    results();
  end
endmodule : adaptive_hysteresis_switcher_test
`default_nettype wire
